/* core/pcfe_pkg.sv */
// Purpose: Shared constants for the counter group filter and enable register slice.
// Assumes: 32-bit register port with byte addresses, eight implemented counters.
// Notes:   Each 64-bit register occupies two words, low word first.
package pcfe_pkg;

  // Sizes of the implemented counter group.
  localparam int NUM_CNT   = 8;
  localparam int CIDX_W    = 3;
  localparam int SID_W     = 16;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int MAP_W     = 64;
  localparam int SHADOW_W  = 64;
  localparam int PART_W    = 16;
  localparam int GROUP_W   = 8;
  localparam int GROUP_LSB = 16;
  localparam int SIZE_W    = 6;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] SHADOW_BASE = 12'h600;
  localparam logic [ADDR_W-1:0] SMR_BASE    = 12'ha00;
  localparam logic [ADDR_W-1:0] CNT_EN_SET  = 12'hc00;
  localparam logic [ADDR_W-1:0] CNT_EN_CLR  = 12'hc20;
  localparam logic [ADDR_W-1:0] INT_EN_SET  = 12'hc40;
  localparam logic [ADDR_W-1:0] INT_EN_CLR  = 12'hc60;
  localparam logic [ADDR_W-1:0] OVF_CLR     = 12'hc80;

  // Array strides, as shift amounts and as covered spans in bytes.
  localparam int NARROW_SHIFT = 2;
  localparam int WIDE_SHIFT   = 3;
  localparam logic [ADDR_W-1:0] NARROW_SPAN = 12'h020;
  localparam logic [ADDR_W-1:0] WIDE_SPAN   = 12'h040;
  localparam logic [ADDR_W-1:0] SMR_SPAN    = 12'h020;
  localparam int HI_WORD_BIT = 2;
  localparam int MAP_SEL_LSB = 3;

  // Counter size encodings: value plus one is the width in bits.
  localparam logic [SIZE_W-1:0] SIZE_NARROW_MAX = 6'h1f;

  // Filter sharing types.
  localparam logic FILT_PER_CNT = 1'b0;
  localparam logic FILT_SHARED  = 1'b1;

  // Field masks of the match register.
  localparam logic [DATA_W-1:0] SID_MASK  = 32'h0000ffff;
  localparam logic [DATA_W-1:0] PART_GROUP_MASK = 32'h00ffffff;

  // Bitmap reset value and implemented-bit mask.
  localparam logic [MAP_W-1:0] MAP_RESET = 64'h0000000000000000;
  localparam logic [MAP_W-1:0] IMPL_MASK = 64'h00000000000000ff;

endpackage

/* core/pcfe_regs.sv */
// Purpose: Shadow values, stream match filters and enable/overflow bitmaps of a counter group.
// Assumes: Counters, event selectors, capture trigger and configuration live outside.
// Notes:   Read data appear one cycle after the read strobe and only in that cycle.
`timescale 1ns/1ns
// Operation
// - Wide shadow values are 64 bits; bits at and above counter width read zero.
// - Shadow values read-only at 0x600, stride 4 or 8; other view reads zero.
// - Shadows and filters reset to unspecified values; software initialises them. Bitmaps reset to zero.
// - Match register exists for counter zero or all counters when per-counter.
// - Partition mode: group in bits 23:16, partition in 15:0, no stream match.
// - Events that cannot be stream filtered ignore the match value and count.
// - Span clear: count only an exact stream identifier match.
// - Span set: low-order run of bits masked out; all ones matches everything.
// - With secure observation, secure select picks secure or non-secure stream space.
// - Stream match field is a contiguous run from bit 0; upper bits zero.
// - Type zero pairs match register with its counter; type one shares register zero.
// - Counter advances only with its enable bit and the group enable both set.
// - Enable-set view sets written ones; reads current enables, unimplemented bits zero.
// - Enable-clear view clears written ones; reads current enables.
// - Interrupt-enable bitmap has 64-bit set and clear views reading current state.
// - Overflow raises interrupt only if its enable and global enable are set then.
// - Overflow clear view: writing one clears a flag, zero has no effect.
// - Counter wrap sets its overflow flag; the clear view reads current flags.
module pcfe_regs
  import pcfe_pkg::*;
(
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst_b,
  // Register port
  input  wire logic [ADDR_W-1:0]           reg_addr,
  input  wire logic [DATA_W-1:0]           reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [DATA_W-1:0]           reg_rdata,
  // Group configuration
  input  wire logic [SIZE_W-1:0]           counter_size,
  input  wire logic                        filter_sharing_type,
  input  wire logic                        global_counter_enable,
  input  wire logic                        global_interrupt_enable,
  input  wire logic                        secure_observe_enable,
  // Per-counter filter options from the event type selectors
  input  wire logic [NUM_CNT-1:0]          match_span_select,
  input  wire logic [NUM_CNT-1:0]          secure_stream_select,
  input  wire logic [NUM_CNT-1:0]          partition_filter_enable,
  input  wire logic [NUM_CNT-1:0]          group_filter_enable,
  // Event stream
  input  wire logic [NUM_CNT-1:0]          evt_hit,
  input  wire logic [NUM_CNT-1:0]          evt_sid_filterable,
  input  wire logic [SID_W-1:0]            evt_stream_id,
  input  wire logic                        evt_secure,
  input  wire logic [PART_W-1:0]           evt_partition_identifier,
  input  wire logic [GROUP_W-1:0]          evt_monitoring_group,
  // Counter interface
  output logic      [NUM_CNT-1:0]          count_advance,
  input  wire logic [NUM_CNT-1:0]          counter_wrap,
  input  wire logic                        capture_strobe,
  input  wire logic [NUM_CNT*SHADOW_W-1:0] capture_value,
  // State and interrupt
  output logic      [MAP_W-1:0]            counter_enable_bitmap,
  output logic      [MAP_W-1:0]            interrupt_enable_bitmap,
  output logic      [MAP_W-1:0]            overflow_flags,
  output logic                             irq
);

  logic [SHADOW_W-1:0] shadow_q [NUM_CNT];
  logic [DATA_W-1:0]   smr_q    [NUM_CNT];
  logic [MAP_W-1:0]    cnt_en_q;
  logic [MAP_W-1:0]    int_en_q;
  logic [MAP_W-1:0]    ovf_q;
  logic [NUM_CNT-1:0]  irq_pend_q;
  logic [NUM_CNT-1:0]  advance_q;
  logic [NUM_CNT-1:0]  advance_d;
  logic [DATA_W-1:0]   rdata_q;
  logic [DATA_W-1:0]   rdata_d;
  logic [MAP_W-1:0]    wr_map;
  logic [ADDR_W-1:0]   shadow_off;
  logic [ADDR_W-1:0]   smr_off;
  logic [CIDX_W-1:0]   smr_idx;
  logic                smr_hit;
  logic                smr_wr;
  logic                wide_mode;

  // Mask of the implemented counter bits for a configured size.
  function automatic logic [SHADOW_W-1:0] width_mask(input logic [SIZE_W-1:0] size);
    logic [SHADOW_W:0] ones;
    ones = {{SHADOW_W{1'b0}}, 1'b1} << ({1'b0, size} + 7'h01);
    return ones[SHADOW_W-1:0] - 64'h0000000000000001;
  endfunction

  // True when the address selects either word of a 64-bit bitmap register.
  function automatic logic map_sel(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] base);
    return addr[ADDR_W-1:MAP_SEL_LSB] == base[ADDR_W-1:MAP_SEL_LSB];
  endfunction

  // Returns the 32-bit word of a 64-bit value chosen by the address.
  function automatic logic [DATA_W-1:0] word_of(input logic [MAP_W-1:0] value,
                                                input logic              hi);
    return hi ? value[MAP_W-1:DATA_W] : value[DATA_W-1:0];
  endfunction

  // Stream bits ignored by a span encoding: trailing ones and the first zero above them.
  function automatic logic [SID_W-1:0] span_ignore(input logic [SID_W-1:0] value);
    return value ^ (value + 16'h0001);
  endfunction

  // Match register selected for a counter under the current sharing type.
  function automatic int unsigned filt_idx(input int unsigned n, input logic ftype);
    return (ftype == FILT_SHARED) ? 0 : n;
  endfunction

  // Partition or group filtering replaces stream matching.
  function automatic logic part_group_mode(input int unsigned n);
    return partition_filter_enable[n] | group_filter_enable[n];
  endfunction

  assign wide_mode  = counter_size > SIZE_NARROW_MAX;
  assign shadow_off = reg_addr - SHADOW_BASE;
  assign smr_off    = reg_addr - SMR_BASE;
  assign smr_idx    = CIDX_W'(smr_off >> NARROW_SHIFT);
  assign smr_hit    = (reg_addr >= SMR_BASE) && (smr_off < SMR_SPAN) &&
                      ((smr_idx == '0) || (filter_sharing_type == FILT_PER_CNT));
  assign smr_wr     = reg_wr && smr_hit;

  // Write data placed into the word lane of a 64-bit bitmap.
  assign wr_map = reg_addr[HI_WORD_BIT] ? {reg_wdata, 32'h00000000}
                                        : {32'h00000000, reg_wdata};

  // Shadow capture; the stored copy is cut to the configured width.
  always_ff @(posedge core_clk) begin
    if (capture_strobe) begin
      for (int n = 0; n < NUM_CNT; n++) begin
        shadow_q[n] <= capture_value[n*SHADOW_W +: SHADOW_W] & width_mask(counter_size);
      end
    end
  end

  // Match registers carry no reset; software programs them first.
  always_ff @(posedge core_clk) begin
    if (smr_wr) begin
      if (part_group_mode(32'(smr_idx))) begin
        smr_q[smr_idx] <= reg_wdata & PART_GROUP_MASK;
      end else begin
        smr_q[smr_idx] <= reg_wdata & SID_MASK;
      end
    end
  end

  // Counter enable bitmap, one store behind both views.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cnt_en_q <= MAP_RESET;
    end else if (reg_wr && map_sel(reg_addr, CNT_EN_SET)) begin
      cnt_en_q <= (cnt_en_q | wr_map) & IMPL_MASK;
    end else if (reg_wr && map_sel(reg_addr, CNT_EN_CLR)) begin
      cnt_en_q <= cnt_en_q & ~wr_map;
    end
  end

  // Interrupt enable bitmap, one store behind both views.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      int_en_q <= MAP_RESET;
    end else if (reg_wr && map_sel(reg_addr, INT_EN_SET)) begin
      int_en_q <= (int_en_q | wr_map) & IMPL_MASK;
    end else if (reg_wr && map_sel(reg_addr, INT_EN_CLR)) begin
      int_en_q <= int_en_q & ~wr_map;
    end
  end

  // Overflow flags; a wrap in the same cycle as a clear keeps the flag set.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ovf_q <= MAP_RESET;
    end else begin
      if (reg_wr && map_sel(reg_addr, OVF_CLR)) begin
        ovf_q <= ((ovf_q & ~wr_map) | {{(MAP_W-NUM_CNT){1'b0}}, counter_wrap}) & IMPL_MASK;
      end else begin
        ovf_q <= (ovf_q | {{(MAP_W-NUM_CNT){1'b0}}, counter_wrap}) & IMPL_MASK;
      end
    end
  end

  // Interrupt pending bits, armed only by enables present at the moment of wrap.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_pend_q <= '0;
    end else begin
      for (int n = 0; n < NUM_CNT; n++) begin
        if (counter_wrap[n] && int_en_q[n] && global_interrupt_enable) begin
          irq_pend_q[n] <= 1'b1;
        end else if (reg_wr && map_sel(reg_addr, OVF_CLR) && wr_map[n]) begin
          irq_pend_q[n] <= 1'b0;
        end
      end
    end
  end

  // Event filtering and enable gating per counter.
  always_comb begin
    logic [DATA_W-1:0] smr;
    logic [SID_W-1:0]  ign;
    logic              sec_ok;
    logic              sid_ok;
    logic              part_ok;
    logic              pass;
    int unsigned       s;
    smr       = '0;
    ign       = '0;
    sec_ok    = 1'b0;
    sid_ok    = 1'b0;
    part_ok   = 1'b0;
    pass      = 1'b0;
    s         = 0;
    advance_d = '0;
    for (int n = 0; n < NUM_CNT; n++) begin
      s   = filt_idx(n, filter_sharing_type);
      smr = smr_q[s];
      ign = span_ignore(smr[SID_W-1:0]);
      if (secure_observe_enable) begin
        sec_ok = evt_secure == secure_stream_select[s];
      end else begin
        sec_ok = !evt_secure;
      end
      if (match_span_select[s]) begin
        sid_ok = sec_ok && (((evt_stream_id ^ smr[SID_W-1:0]) & ~ign) == '0);
      end else begin
        sid_ok = sec_ok && (evt_stream_id == smr[SID_W-1:0]);
      end
      part_ok = (!partition_filter_enable[s] ||
                 (evt_partition_identifier == smr[PART_W-1:0])) &&
                (!group_filter_enable[s] ||
                 (evt_monitoring_group == smr[GROUP_LSB +: GROUP_W]));
      if (!evt_sid_filterable[n]) begin
        pass = 1'b1;
      end else if (part_group_mode(s)) begin
        pass = part_ok;
      end else begin
        pass = sid_ok;
      end
      advance_d[n] = evt_hit[n] && pass && cnt_en_q[n] && global_counter_enable;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      advance_q <= '0;
    end else begin
      advance_q <= advance_d;
    end
  end

  // Read decode; unmapped and absent registers read zero.
  always_comb begin
    logic [CIDX_W-1:0] idx;
    idx     = '0;
    rdata_d = '0;
    if (reg_addr >= SHADOW_BASE && !wide_mode && shadow_off < NARROW_SPAN) begin
      idx     = CIDX_W'(shadow_off >> NARROW_SHIFT);
      rdata_d = shadow_q[idx][DATA_W-1:0];
    end else if (reg_addr >= SHADOW_BASE && wide_mode && shadow_off < WIDE_SPAN) begin
      idx     = CIDX_W'(shadow_off >> WIDE_SHIFT);
      rdata_d = word_of(shadow_q[idx], shadow_off[HI_WORD_BIT]);
    end else if (smr_hit) begin
      rdata_d = smr_q[smr_idx] &
                (part_group_mode(32'(smr_idx)) ? PART_GROUP_MASK : SID_MASK);
    end else if (map_sel(reg_addr, CNT_EN_SET) || map_sel(reg_addr, CNT_EN_CLR)) begin
      rdata_d = word_of(cnt_en_q, reg_addr[HI_WORD_BIT]);
    end else if (map_sel(reg_addr, INT_EN_SET) || map_sel(reg_addr, INT_EN_CLR)) begin
      rdata_d = word_of(int_en_q, reg_addr[HI_WORD_BIT]);
    end else if (map_sel(reg_addr, OVF_CLR)) begin
      rdata_d = word_of(ovf_q, reg_addr[HI_WORD_BIT]);
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata               = rdata_q;
  assign count_advance           = advance_q;
  assign counter_enable_bitmap   = cnt_en_q;
  assign interrupt_enable_bitmap = int_en_q;
  assign overflow_flags          = ovf_q;
  assign irq                     = |irq_pend_q;

endmodule

/* tb/pcfe_regs_monitor.sv */
// Purpose: Port-level checks of the counter group register slice.
// Assumes: Eight counters, so only bitmap bits 7:0 are implemented.
// Notes:   Bound to every instance of pcfe_regs.
`timescale 1ns/1ns
module pcfe_regs_monitor
  import pcfe_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_b,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  // Events and state
  input wire logic              global_counter_enable,
  input wire logic              global_interrupt_enable,
  input wire logic [NUM_CNT-1:0] evt_hit,
  input wire logic [NUM_CNT-1:0] count_advance,
  input wire logic [NUM_CNT-1:0] counter_wrap,
  input wire logic [MAP_W-1:0]  counter_enable_bitmap,
  input wire logic [MAP_W-1:0]  interrupt_enable_bitmap,
  input wire logic [MAP_W-1:0]  overflow_flags,
  input wire logic              irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_en_set;
    reg_wr && reg_addr == CNT_EN_SET |=>
      (counter_enable_bitmap[7:0] & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]);
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable set lost");
  property p_en_clr;
    reg_wr && reg_addr == CNT_EN_CLR |=> (counter_enable_bitmap[7:0] & $past(reg_wdata[7:0])) == 0;
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("enable clear lost");
  property p_ie_set;
    reg_wr && reg_addr == INT_EN_SET |=>
      (interrupt_enable_bitmap[7:0] & $past(reg_wdata[7:0])) == $past(reg_wdata[7:0]);
  endproperty
  a_ie_set: assert property (p_ie_set) else $error("int enable set lost");
  property p_ie_clr;
    reg_wr && reg_addr == INT_EN_CLR |=> (interrupt_enable_bitmap[7:0] & $past(reg_wdata[7:0])) == 0;
  endproperty
  a_ie_clr: assert property (p_ie_clr) else $error("int enable clear lost");
  property p_hi_zero;
    counter_enable_bitmap[63:8] == 0 && interrupt_enable_bitmap[63:8] == 0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("unimplemented bit set");
  property p_advance;
    count_advance != 8'h00 |-> $past(global_counter_enable) &&
      (count_advance & ~$past(evt_hit & counter_enable_bitmap[7:0])) == 8'h00;
  endproperty
  a_advance: assert property (p_advance) else $error("advance without enable");
  property p_wrap;
    counter_wrap != 8'h00 |=> (overflow_flags[7:0] & $past(counter_wrap)) == $past(counter_wrap);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag missing");
  property p_ovs_clr;
    reg_wr && reg_addr == OVF_CLR && counter_wrap == 8'h00 |=>
      (overflow_flags[7:0] & $past(reg_wdata[7:0])) == 8'h00;
  endproperty
  a_ovs_clr: assert property (p_ovs_clr) else $error("overflow clear lost");
  property p_irq_rise;
    $rose(irq) |-> $past(global_interrupt_enable) &&
      $past(counter_wrap & interrupt_enable_bitmap[7:0]) != 8'h00;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without enabled wrap");

  c_irq: cover property ($rose(irq));
  c_adv: cover property (count_advance != 8'h00);
  c_clr: cover property (reg_wr && reg_addr == OVF_CLR && overflow_flags != 0);
endmodule

bind pcfe_regs pcfe_regs_monitor pcfe_regs_monitor_inst (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .global_counter_enable(global_counter_enable),
  .global_interrupt_enable(global_interrupt_enable), .evt_hit(evt_hit),
  .count_advance(count_advance), .counter_wrap(counter_wrap),
  .counter_enable_bitmap(counter_enable_bitmap),
  .interrupt_enable_bitmap(interrupt_enable_bitmap), .overflow_flags(overflow_flags), .irq(irq));

/* tb/pcfe_regs_bench.sv */
// Purpose: Register, event and overflow tests of the counter group slice.
// Assumes: One-cycle strobes; read data checked in the cycle after the strobe.
// Notes:   Each access leaves a one-cycle gap so no strobe is driven twice at one edge.
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module pcfe_regs_bench
  import pcfe_pkg::*;
;
  logic core_clk, rst_b, reg_wr, reg_rd, irq, evt_secure, capture_strobe;
  logic filter_sharing_type, global_counter_enable, global_interrupt_enable, secure_observe_enable;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [SIZE_W-1:0] counter_size;
  logic [NUM_CNT-1:0] match_span_select, secure_stream_select, partition_filter_enable;
  logic [NUM_CNT-1:0] group_filter_enable, evt_hit, evt_sid_filterable, count_advance;
  logic [NUM_CNT-1:0] counter_wrap;
  logic [SID_W-1:0] evt_stream_id;
  logic [PART_W-1:0] evt_partition_identifier;
  logic [GROUP_W-1:0] evt_monitoring_group;
  logic [NUM_CNT*SHADOW_W-1:0] capture_value;
  logic [MAP_W-1:0] counter_enable_bitmap, interrupt_enable_bitmap, overflow_flags;
  int n_fail, compares;

  pcfe_regs pcfe_regs_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .counter_size(counter_size), .filter_sharing_type(filter_sharing_type),
    .global_counter_enable(global_counter_enable),
    .global_interrupt_enable(global_interrupt_enable),
    .secure_observe_enable(secure_observe_enable), .match_span_select(match_span_select),
    .secure_stream_select(secure_stream_select),
    .partition_filter_enable(partition_filter_enable), .group_filter_enable(group_filter_enable),
    .evt_hit(evt_hit), .evt_sid_filterable(evt_sid_filterable), .evt_stream_id(evt_stream_id),
    .evt_secure(evt_secure), .evt_partition_identifier(evt_partition_identifier),
    .evt_monitoring_group(evt_monitoring_group), .count_advance(count_advance),
    .counter_wrap(counter_wrap), .capture_strobe(capture_strobe), .capture_value(capture_value),
    .counter_enable_bitmap(counter_enable_bitmap),
    .interrupt_enable_bitmap(interrupt_enable_bitmap), .overflow_flags(overflow_flags), .irq(irq));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // Fires one event cycle and checks the advance pulse that follows it.
  task automatic ev(input logic [7:0] h, input logic [SID_W-1:0] s, input logic [7:0] e);
    @(posedge core_clk);
    evt_hit <= h;
    evt_stream_id <= s;
    @(posedge core_clk);
    evt_hit <= 8'h00;
    #1 `CHK(count_advance, e)
  endtask

  task automatic pulse_wrap(input logic [7:0] b);
    @(posedge core_clk);
    counter_wrap <= b;
    @(posedge core_clk);
    counter_wrap <= 8'h00;
    #1;
  endtask

  task automatic capture(input logic [SIZE_W-1:0] sz);
    @(posedge core_clk) counter_size <= sz;
    @(posedge core_clk) capture_strobe <= 1'b1;
    @(posedge core_clk) capture_strobe <= 1'b0;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end

  initial begin
    {rst_b, reg_wr, reg_rd, evt_secure, capture_strobe, filter_sharing_type} = '0;
    {secure_observe_enable, match_span_select, secure_stream_select} = '0;
    {partition_filter_enable, group_filter_enable, evt_hit, counter_wrap} = '0;
    {reg_addr, reg_wdata, evt_stream_id, evt_partition_identifier, evt_monitoring_group} = '0;
    {global_counter_enable, global_interrupt_enable} = 2'b11;
    evt_sid_filterable = 8'hff;
    counter_size = 6'h1f;
    capture_value = {8{64'hfedcba9876543210}};
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    wr(CNT_EN_SET, 32'h5);
    rd(CNT_EN_CLR, 32'h5);
    wr(CNT_EN_CLR, 32'h1);
    rd(CNT_EN_SET, 32'h4);
    wr(CNT_EN_SET, 32'hffffffff);
    rd(CNT_EN_SET, 32'hff);
    wr(CNT_EN_SET + 12'h004, 32'hffffffff);
    rd(CNT_EN_SET + 12'h004, 32'h0);
    wr(INT_EN_SET, 32'hc);
    wr(INT_EN_CLR, 32'h8);
    rd(INT_EN_SET, 32'h4);
    pulse_wrap(8'h04);
    `CHK(irq, 1'b1)
    pulse_wrap(8'h02);
    rd(OVF_CLR, 32'h6);
    wr(OVF_CLR, 32'h4);
    `CHK(irq, 1'b0)
    @(posedge core_clk) global_interrupt_enable <= 1'b0;
    pulse_wrap(8'h04);
    `CHK(irq, 1'b0)
    wr(OVF_CLR, 32'h0);
    rd(OVF_CLR, 32'h6);
    capture(6'h1f);
    rd(SHADOW_BASE + 12'h004, 32'h76543210);
    wr(SHADOW_BASE + 12'h004, 32'h0);
    rd(SHADOW_BASE + 12'h004, 32'h76543210);
    rd(SHADOW_BASE + 12'h024, 32'h0);
    capture(6'h27);
    rd(SHADOW_BASE + 12'h00c, 32'h98);
    capture(6'h3f);
    rd(SHADOW_BASE + 12'h00c, 32'hfedcba98);
    wr(SMR_BASE, 32'h12345678);
    rd(SMR_BASE, 32'h5678);
    wr(SMR_BASE + 12'h004, 32'h42);
    ev(8'h03, 16'h5678, 8'h01);
    ev(8'h03, 16'h0042, 8'h02);
    @(posedge core_clk) evt_sid_filterable <= 8'hfe;
    ev(8'h03, 16'h0042, 8'h03);
    @(posedge core_clk) {evt_sid_filterable, match_span_select} <= {8'hff, 8'h01};
    wr(SMR_BASE, 32'h5677);
    ev(8'h01, 16'h5670, 8'h01);
    ev(8'h01, 16'h5680, 8'h00);
    wr(SMR_BASE, 32'hffff);
    ev(8'h01, 16'h1357, 8'h01);
    @(posedge core_clk) evt_secure <= 1'b1;
    ev(8'h01, 16'h1357, 8'h00);
    @(posedge core_clk) {secure_observe_enable, secure_stream_select} <= {1'b1, 8'h01};
    ev(8'h01, 16'h1357, 8'h01);
    @(posedge core_clk) global_counter_enable <= 1'b0;
    ev(8'h01, 16'h1357, 8'h00);
    @(posedge core_clk) {global_counter_enable, secure_observe_enable, evt_secure} <= 3'b100;
    wr(CNT_EN_CLR, 32'h1);
    ev(8'h01, 16'h1357, 8'h00);
    wr(CNT_EN_SET, 32'h1);
    @(posedge core_clk) filter_sharing_type <= 1'b1;
    rd(SMR_BASE + 12'h004, 32'h0);
    ev(8'h02, 16'h1357, 8'h02);
    @(posedge core_clk) {filter_sharing_type, partition_filter_enable} <= {1'b0, 8'h01};
    wr(SMR_BASE, 32'hab123456);
    rd(SMR_BASE, 32'h00123456);
    @(posedge core_clk) evt_partition_identifier <= 16'h3456;
    ev(8'h01, 16'h0000, 8'h01);
    @(posedge core_clk) evt_partition_identifier <= 16'h3457;
    ev(8'h01, 16'h0000, 8'h00);
    stop_test();
  end
endmodule
